// ==== inc/adc_compute_defs.svh ====
// Register offsets, field positions, reset values and limits of the post-conversion compute unit
`ifndef ADC_COMPUTE_DEFS_SVH
`define ADC_COMPUTE_DEFS_SVH
`define ACP_OFF_CTRL 8'h00
`define ACP_OFF_RPT 8'h04
`define ACP_OFF_ACC 8'h08
`define ACP_OFF_CNT 8'h0c
`define ACP_OFF_FILT 8'h10
`define ACP_OFF_STAT 8'h14
`define ACP_OFF_CLR 8'h18
`define ACP_OFF_EN 8'h1c
`define ACP_OFF_PREV 8'h20
`define ACP_CTRL_MODE_LSB 0
`define ACP_CTRL_DOUBLE_SAMPLE_EN_BIT 3
`define ACP_CTRL_SHIFT_LSB 4
`define ACP_CTRL_ACCUM_CLEAR_CTRL_BIT 8
`define ACP_CTRL_START_BIT 9
`define ACP_ST_DONE 0
`define ACP_ST_THR 1
`define ACP_ST_OVF 2
`define ACP_RST_RPT 8'h00
`define ACP_RST_SHIFT 3'h0
`define ACP_CNT_MAX 8'hff
`define ACP_ACC_MAX 20'h3ffff
`endif

// ==== inc/adc_compute_pkg.sv ====
// Types shared by the post-conversion compute unit
package adc_compute_pkg;
	typedef enum logic [2:0] {
		MODE_BASIC = 3'h0,
		MODE_ACCUM = 3'h1,
		MODE_AVG = 3'h2,
		MODE_BURST = 3'h3,
		MODE_LPF = 3'h4
	} compute_mode_t;
	typedef enum logic [1:0] {
		PH_FIRST = 2'h1,
		PH_SECOND = 2'h2
	} phase_t;
	typedef struct packed {
		logic done;
		logic trigger;
		logic thrMet;
		logic [11:0] result;
	} conv_in_t;
	typedef struct packed {
		logic convStart;
		logic testDue;
		logic [17:0] filterOut;
	} core_req_t;
endpackage

// ==== core/adc_post_conversion_compute.sv ====
// Post-conversion compute unit: accumulator, counter, filter and threshold scheduling
`timescale 1ns/1ps
`default_nettype none
`include "adc_compute_defs.svh"

// Notes on behaviour
// - Three-bit mode code picks one of five modes
// - Double sampling off: one conversion, on: pair
// - Basic: done flag each conversion, accumulator untouched
// - Accumulate: add, count saturating at 0xff, test
// - Average: test only once count reaches target
// - Average: start after target clears accumulator first
// - Burst: every start clears accumulator and count
// - Burst: retrigger below target, end at target
// - Low-pass: acc plus sample minus shifted acc
// - Low-pass: test from target onward, not cleared by a start
// - Cycle is one or two conversions, one update
// - Sample is result, or result minus previous
// - Filter output is shifted accumulator after update
// - 18-bit accumulator, overflow flag above 262143
// - Clear control empties accumulator and count, drops overflow flag, then self-clears
module adc_post_conversion_compute
	import adc_compute_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	output logic wb_ack_o,
	input wire conv_in_t convIn,
	output core_req_t coreReq,
	output logic irq
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rstMeta_r;
	logic rstN_r;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_r <= 1'b0;
			rstN_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN_r <= rstMeta_r;
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] laneMerge(input logic [31:0] oldVal,
			input logic [31:0] newVal, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (oldVal & ~m) | (newVal & m);
	endfunction

	function automatic logic isAccMode(input compute_mode_t m);
		return (m == MODE_ACCUM) || (m == MODE_AVG) || (m == MODE_BURST) || (m == MODE_LPF);
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	compute_mode_t mode_r;
	logic double_sample_en_r;
	logic [2:0] shift_r;
	logic accum_clear_ctrl_r;
	logic [7:0] rpt_r;
	logic [2:0] status_r;
	logic [2:0] irqEn_r;
	logic [17:0] acc_r;
	logic [7:0] cnt_r;
	logic [17:0] filter_r;
	logic [11:0] prev_r;
	phase_t phase_r;
	logic ack_r;
	logic [31:0] rdData_r;

	logic busReq;
	logic wrEn;
	logic wrCtrl;
	logic [31:0] ctrlWord;
	logic [31:0] ctrlNew;
	logic [31:0] rdMux;
	logic swStart;

	assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wrEn = busReq & wb_we_i & clkEn;
	assign wrCtrl = wrEn && (wb_adr_i == `ACP_OFF_CTRL);
	assign ctrlWord = {22'h0, 1'b0, accum_clear_ctrl_r, 1'b0, shift_r, double_sample_en_r, mode_r};
	assign ctrlNew = laneMerge(ctrlWord, wb_dat_i, wb_sel_i);
	assign swStart = wrCtrl & ctrlNew[`ACP_CTRL_START_BIT];

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	always_comb begin
		case (wb_adr_i)
			`ACP_OFF_CTRL: rdMux = ctrlWord;
			`ACP_OFF_RPT: rdMux = {24'h0, rpt_r};
			`ACP_OFF_ACC: rdMux = {14'h0, acc_r};
			`ACP_OFF_CNT: rdMux = {24'h0, cnt_r};
			`ACP_OFF_FILT: rdMux = {14'h0, filter_r};
			`ACP_OFF_STAT: rdMux = {29'h0, status_r};
			`ACP_OFF_EN: rdMux = {29'h0, irqEn_r};
			`ACP_OFF_PREV: rdMux = {20'h0, prev_r};
			default: rdMux = 32'h0;
		endcase
	end

	// One wait state: every access, mapped or not, is acknowledged
	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			ack_r <= 1'b0;
			rdData_r <= 32'h0;
		end else if (clkEn) begin
			ack_r <= busReq;
			if (busReq && !wb_we_i) begin
				rdData_r <= rdMux;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdData_r;

	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			mode_r <= MODE_BASIC;
			double_sample_en_r <= 1'b0;
			shift_r <= `ACP_RST_SHIFT;
			rpt_r <= `ACP_RST_RPT;
			irqEn_r <= 3'h0;
		end else if (wrEn) begin
			if (wb_adr_i == `ACP_OFF_CTRL) begin
				mode_r <= compute_mode_t'(ctrlNew[`ACP_CTRL_MODE_LSB +: 3]);
				double_sample_en_r <= ctrlNew[`ACP_CTRL_DOUBLE_SAMPLE_EN_BIT];
				shift_r <= ctrlNew[`ACP_CTRL_SHIFT_LSB +: 3];
			end
			if (wb_adr_i == `ACP_OFF_RPT) begin
				rpt_r <= wb_sel_i[0] ? wb_dat_i[7:0] : rpt_r;
			end
			if (wb_adr_i == `ACP_OFF_EN) begin
				irqEn_r <= wb_sel_i[0] ? wb_dat_i[2:0] : irqEn_r;
			end
		end
	end

	// Software sets the clear, hardware drops it once the clear has been applied
	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			accum_clear_ctrl_r <= 1'b0;
		end else if (clkEn) begin
			if (wrCtrl && ctrlNew[`ACP_CTRL_ACCUM_CLEAR_CTRL_BIT]) begin
				accum_clear_ctrl_r <= 1'b1;
			end else begin
				accum_clear_ctrl_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	logic cycleDone;
	logic startEvt;
	logic startClr;
	logic signed [12:0] sampleVal;
	logic [17:0] accBase;
	logic [7:0] cntBase;
	logic [19:0] accExt;
	logic [19:0] sampExt;
	logic [19:0] sum;
	logic [7:0] cntNext;
	logic accumulate;
	logic ovfNow;
	logic testNxt;
	logic retrig;

	// A cycle closes on every conversion, or on the second of a pair
	assign cycleDone = convIn.done & (~double_sample_en_r | (phase_r == PH_SECOND));
	assign startEvt = swStart | convIn.trigger;
	assign sampleVal = double_sample_en_r ? ($signed({1'b0, convIn.result}) - $signed({1'b0, prev_r}))
		: $signed({1'b0, convIn.result});
	assign accumulate = cycleDone & isAccMode(mode_r);

	always_comb begin
		startClr = 1'b0;
		case (mode_r)
			MODE_AVG: startClr = startEvt && (cnt_r >= rpt_r);
			MODE_BURST: startClr = startEvt;
			default: startClr = 1'b0;
		endcase
	end

	assign accBase = startClr ? 18'h0 : acc_r;
	assign cntBase = startClr ? 8'h00 : cnt_r;
	assign accExt = {2'h0, accBase};
	assign sampExt = {{7{sampleVal[12]}}, sampleVal};
	// Low-pass leaks a shifted share of the accumulator each cycle
	assign sum = accExt + sampExt - ((mode_r == MODE_LPF) ? (accExt >> shift_r) : 20'h0);
	assign cntNext = (cntBase == `ACP_CNT_MAX) ? cntBase : cntBase + 8'h01;
	// Negative sums wrap and are flagged too; the flag is then the only trustworthy hint
	assign ovfNow = accumulate && !accum_clear_ctrl_r && (sum > `ACP_ACC_MAX);

	always_comb begin
		testNxt = 1'b0;
		retrig = 1'b0;
		case (mode_r)
			MODE_BASIC: testNxt = cycleDone;
			MODE_ACCUM: testNxt = cycleDone;
			MODE_AVG: testNxt = cycleDone && (cntNext >= rpt_r);
			MODE_BURST: begin
				testNxt = cycleDone && (cntNext >= rpt_r);
				retrig = cycleDone && (cntNext < rpt_r);
			end
			MODE_LPF: testNxt = cycleDone && (cntNext >= rpt_r);
			default: testNxt = cycleDone;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			acc_r <= 18'h0;
			cnt_r <= 8'h00;
			filter_r <= 18'h0;
		end else if (clkEn) begin
			if (accum_clear_ctrl_r) begin
				acc_r <= 18'h0;
				cnt_r <= 8'h00;
			end else if (accumulate) begin
				acc_r <= sum[17:0];
				cnt_r <= cntNext;
				filter_r <= sum[17:0] >> shift_r;
			end else if (startClr) begin
				acc_r <= 18'h0;
				cnt_r <= 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			prev_r <= 12'h0;
			phase_r <= PH_FIRST;
		end else if (clkEn) begin
			if (convIn.done) begin
				prev_r <= convIn.result;
				case (phase_r)
					PH_FIRST: phase_r <= double_sample_en_r ? PH_SECOND : PH_FIRST;
					PH_SECOND: phase_r <= PH_FIRST;
					default: phase_r <= PH_FIRST;
				endcase
			end else if (!double_sample_en_r) begin
				phase_r <= PH_FIRST;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			coreReq <= '0;
		end else if (clkEn) begin
			coreReq.convStart <= swStart | (retrig & ~accum_clear_ctrl_r);
			coreReq.testDue <= testNxt;
			coreReq.filterOut <= accum_clear_ctrl_r ? filter_r : accumulate ? (sum[17:0] >> shift_r) : filter_r;
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	logic [2:0] setBits;
	logic [2:0] clrBits;

	assign setBits = {ovfNow, testNxt & (convIn.thrMet | ovfNow), convIn.done};
	assign clrBits = (wrEn && (wb_adr_i == `ACP_OFF_CLR) && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

	// A new event beats a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rstN_r) begin
		if (!rstN_r) begin
			status_r <= 3'h0;
		end else if (clkEn) begin
			status_r <= (status_r & ~clrBits & ~{accum_clear_ctrl_r, 2'b00}) | setBits;
		end
	end

	assign irq = |(status_r & irqEn_r);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstN_r);

	chk_cnt_saturate: assert property (clkEn && accumulate && !accum_clear_ctrl_r && !startClr
		&& cnt_r == `ACP_CNT_MAX |=> cnt_r == `ACP_CNT_MAX) else $error("counter left 0xff");
	chk_basic_hold: assert property (clkEn && mode_r == MODE_BASIC && !accum_clear_ctrl_r
		|=> $stable(acc_r) && $stable(cnt_r)) else $error("basic mode moved accumulator");
	chk_done_flag: assert property (clkEn && convIn.done |=> status_r[`ACP_ST_DONE])
		else $error("done flag not set");
	chk_burst_retrig: assert property (clkEn && retrig && !accum_clear_ctrl_r
		|=> coreReq.convStart && !coreReq.testDue) else $error("burst retrigger missing");
	chk_accum_clear_ctrl_clears: assert property (clkEn && accum_clear_ctrl_r && !wrCtrl
		|=> acc_r == 18'h0 && cnt_r == 8'h00 && !accum_clear_ctrl_r) else $error("clear incomplete");
	chk_filter_copy: assert property (clkEn && accumulate && !accum_clear_ctrl_r
		|=> filter_r == (acc_r >> $past(shift_r))) else $error("filter output stale");
	chk_ovf_flag: assert property (clkEn && ovfNow && !accum_clear_ctrl_r |=> status_r[`ACP_ST_OVF]
		&& (status_r[`ACP_ST_THR] || !coreReq.testDue)) else $error("overflow missed");
	chk_avg_gate: assert property (clkEn && mode_r == MODE_AVG && cycleDone
		&& cntNext < rpt_r |=> !coreReq.testDue) else $error("early average test");
	chk_burst_start: assert property (clkEn && mode_r == MODE_BURST && startEvt
		&& !accum_clear_ctrl_r && !cycleDone |=> cnt_r == 8'h00) else $error("burst start kept count");
	chk_avg_restart: assert property (clkEn && mode_r == MODE_AVG && startEvt
		&& cnt_r >= rpt_r && !cycleDone |=> cnt_r == 8'h00) else $error("average not restarted");
	chk_lpf_retest: assert property (clkEn && mode_r == MODE_LPF && cycleDone
		&& cnt_r >= rpt_r && !accum_clear_ctrl_r |=> coreReq.testDue && cnt_r != 8'h00)
		else $error("low-pass test missing");
	chk_pair_first: assert property (clkEn && double_sample_en_r && convIn.done && phase_r == PH_FIRST
		&& !accum_clear_ctrl_r && !startClr |=> !coreReq.testDue ##0 $stable(acc_r)) else $error("pair closed");

	cov_burst_end: cover property (mode_r == MODE_BURST && coreReq.testDue);
	cov_pair_test: cover property (double_sample_en_r && coreReq.testDue && mode_r == MODE_ACCUM);
	cov_lpf_test: cover property (mode_r == MODE_LPF && coreReq.testDue);
	cov_overflow: cover property (status_r[`ACP_ST_OVF] && irq);

endmodule // adc_post_conversion_compute
`default_nettype wire

// ==== verification/conv_core_model.sv ====
// Behavioural conversion core that answers start requests with finished results
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
	import adc_compute_pkg::*;
(
	input wire logic clk_sys,
	input wire logic kick,
	input wire logic [3:0] lat,
	input wire logic [11:0] nextRes,
	input wire logic thrIn,
	input wire core_req_t coreReq,
	output conv_in_t convIn
);
	logic [3:0] waitCnt = 4'h0;
	logic busy = 1'b0;
	logic done = 1'b0;
	logic trig = 1'b0;
	logic [11:0] lastRes = 12'h000;
	always_ff @(posedge clk_sys) begin
		trig <= kick;
		done <= 1'b0;
		if (kick || coreReq.convStart) begin
			busy <= 1'b1;
			waitCnt <= lat;
		end else if (busy && waitCnt != 4'h0) begin
			waitCnt <= waitCnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			done <= 1'b1;
			lastRes <= nextRes;
		end
	end
	// Result and threshold lines are only valid with done, so they show junk otherwise
	assign convIn = '{done, trig, done ? thrIn : ~thrIn, done ? lastRes : ~lastRes};
endmodule // conv_core_model
`default_nettype wire

// ==== verification/adc_post_conversion_compute_bench.sv ====
// Self-checking bench for the post-conversion compute unit
`timescale 1ns/1ps
`default_nettype none
`include "adc_compute_defs.svh"
module adc_post_conversion_compute_bench;
	import adc_compute_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic we = 1'b0, stb = 1'b0, ack, irq, kick = 1'b0, thr = 1'b0;
	logic [3:0] lat = 4'h1;
	logic [11:0] res = 12'h000;
	conv_in_t convIn;
	core_req_t coreReq;
	int errors = 0, num_checks = 0, tdCnt = 0, csCnt = 0, cyc = 0, td0, cs0;
	adc_post_conversion_compute adc_post_conversion_compute_inst (.clk_sys(clk_sys),
		.reset_n(reset_n), .clkEn(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_we_i(we), .wb_sel_i(4'hf), .wb_stb_i(stb), .wb_cyc_i(stb), .wb_ack_o(ack),
		.convIn(convIn), .coreReq(coreReq), .irq(irq));
	conv_core_model conv_core_model_inst (.clk_sys(clk_sys), .kick(kick), .lat(lat),
		.nextRes(res), .thrIn(thr), .coreReq(coreReq), .convIn(convIn));
	initial forever #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (coreReq.testDue === 1'b1) tdCnt++;
		if (coreReq.convStart === 1'b1) csCnt++;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("Checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Classic single cycle; the slave's ack is the only thing that ends the wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		we <= w;
		stb <= 1'b1;
		do @(posedge clk_sys); while (ack !== 1'b1);
		rd = rdat;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(rd, exp, what);
	endtask
	task automatic conv(input logic [11:0] v);
		res <= v;
		kick <= 1'b1;
		@(posedge clk_sys);
		kick <= 1'b0;
		do @(posedge clk_sys); while (convIn.done !== 1'b1);
		repeat (2) @(posedge clk_sys);
	endtask
	function automatic logic [31:0] cw(input logic [2:0] m, input logic ds, input logic [2:0] sh,
		input logic [1:0] ctl);
		return {22'h0, ctl, 1'b0, sh, ds, m};
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdchk(`ACP_OFF_CTRL, 32'h0, "ctrl reset");
		rdchk(`ACP_OFF_CNT, 32'h0, "cnt reset");
		rdchk(8'h40, 32'h0, "unmapped");
		conv(12'h123);
		rdchk(`ACP_OFF_ACC, 32'h0, "acc basic");
		rdchk(`ACP_OFF_STAT, 32'h1, "stat basic");
		check(tdCnt, 32'h1, "test basic");
		check(irq, 1'b0, "irq masked");
		bus(1'b1, `ACP_OFF_EN, 32'h1);
		check(irq, 1'b1, "irq on");
		bus(1'b1, `ACP_OFF_CLR, 32'h1);
		check(irq, 1'b0, "irq clear");
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h1, 1'b0, 3'h1, 2'h0));
		thr <= 1'b1;
		conv(12'h005);
		conv(12'h005);
		rdchk(`ACP_OFF_ACC, 32'ha, "acc accum");
		rdchk(`ACP_OFF_CNT, 32'h2, "cnt accum");
		rdchk(`ACP_OFF_FILT, 32'h5, "filt accum");
		rdchk(`ACP_OFF_STAT, 32'h3, "stat accum");
		bus(1'b1, `ACP_OFF_RPT, 32'h2);
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h2, 1'b0, 3'h0, 2'h1));
		td0 = tdCnt;
		conv(12'h003);
		conv(12'h003);
		check(tdCnt - td0, 32'h1, "test avg");
		conv(12'h007);
		rdchk(`ACP_OFF_ACC, 32'h7, "acc avg restart");
		check(tdCnt - td0, 32'h1, "no test avg");
		bus(1'b1, `ACP_OFF_RPT, 32'h3);
		res <= 12'h004;
		lat <= 4'h5;
		// Burst mode must be in place before the start write for its clear to apply
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h3, 1'b0, 3'h0, 2'h0));
		td0 = tdCnt;
		cs0 = csCnt;
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h3, 1'b0, 3'h0, 2'h2));
		while (tdCnt == td0) @(posedge clk_sys);
		repeat (3) @(posedge clk_sys);
		rdchk(`ACP_OFF_ACC, 32'hc, "acc burst");
		rdchk(`ACP_OFF_CNT, 32'h3, "cnt burst");
		check(csCnt - cs0, 32'h3, "retrig burst");
		lat <= 4'h1;
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h4, 1'b0, 3'h1, 2'h1));
		td0 = tdCnt;
		repeat (4) conv(12'h008);
		rdchk(`ACP_OFF_ACC, 32'hf, "acc lpf");
		rdchk(`ACP_OFF_FILT, 32'h7, "filt lpf");
		check(coreReq.filterOut, 32'h7, "filt out lpf");
		check(tdCnt - td0, 32'h2, "test lpf");
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h1, 1'b1, 3'h0, 2'h1));
		conv(12'h00a);
		conv(12'h00f);
		rdchk(`ACP_OFF_ACC, 32'h5, "acc pair");
		rdchk(`ACP_OFF_CNT, 32'h1, "cnt pair");
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h1, 1'b0, 3'h0, 2'h1));
		repeat (256) conv(12'hfff);
		rdchk(`ACP_OFF_CNT, 32'hff, "cnt sat");
		bus(1'b0, `ACP_OFF_STAT, 32'h0);
		check(rd[2], 1'b1, "overflow");
		bus(1'b1, `ACP_OFF_CTRL, cw(3'h1, 1'b0, 3'h0, 2'h1));
		rdchk(`ACP_OFF_ACC, 32'h0, "acc clear");
		rdchk(`ACP_OFF_CTRL, 32'h1, "clear self");
		bus(1'b0, `ACP_OFF_STAT, 32'h0);
		check(rd[2], 1'b0, "overflow clear");
		wrap_up();
	end
endmodule // adc_post_conversion_compute_bench
`default_nettype wire
